//--- design/tfd_pkg.sv
package tfd_pkg;

  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 32;

  // Page size codes reported in the identification field
  localparam logic       PAGE_4K  = 1'b0;
  localparam logic       PAGE_64K = 1'b1;
  localparam int unsigned PAGE_SHIFT_4K  = 12;
  localparam int unsigned PAGE_SHIFT_64K = 16;

  // Global page indices
  localparam logic [7:0] PG_GR0  = 8'h00;
  localparam logic [7:0] PG_GR1  = 8'h01;
  localparam logic [7:0] PG_IMPL = 8'h02;
  localparam logic [7:0] PG_PERF = 8'h03;
  localparam logic [7:0] PG_SSD  = 8'h04;

  // Decoder's own registers, byte offsets inside global page 0
  localparam logic [11:0] OFF_ID1   = 12'h024;
  localparam logic [11:0] OFF_SCR1  = 12'h004;
  localparam logic [11:0] OFF_ALIAS = 12'h0f0;

  // Identification field positions
  localparam int unsigned ID1_CB_LSB     = 0;
  localparam int unsigned ID1_S2CB_LSB   = 16;
  localparam int unsigned ID1_NDX_LSB    = 28;
  localparam int unsigned ID1_PGSZ_BIT   = 31;
  // Secure configuration field positions
  localparam int unsigned SCR1_GLOBAL_SECURE_RESTRICT_ENABLE_BIT = 28;
  localparam int unsigned SCR1_IMPEX_BIT  = 27;
  localparam logic [DATA_W-1:0] SCR1_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    TFD_R_NONE, TFD_R_GR0, TFD_R_GR1, TFD_R_IMPL,
    TFD_R_PERF, TFD_R_SSD, TFD_R_CB
  } tfd_region_e;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic              secure;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tfd_req_s;

  typedef struct packed {
    tfd_region_e       region;
    logic [7:0]        page;
    logic [15:0]       word;
    logic              ns_view;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
  } tfd_route_s;

endpackage

//--- design/tfd_page_split.sv
`timescale 1ns/1ns
`default_nettype none
// Splits a frame offset into half, page number and word within the page
module tfd_page_split #(
  parameter int unsigned ADDR_W = 24
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              page_64k,
  input  wire logic [3:0]        ndx,
  output logic                   upper_half,
  output logic [7:0]             page,
  output logic [15:0]            word
);
  logic [ADDR_W-1:0] pg_all;
  logic [ADDR_W-1:0] mask;
  logic [4:0]        sh;
  always_comb begin
    sh         = page_64k ? 5'(tfd_pkg::PAGE_SHIFT_64K) : 5'(tfd_pkg::PAGE_SHIFT_4K);
    pg_all     = addr >> sh;
    mask       = (ADDR_W'(1) << (ndx + 4'd1)) - ADDR_W'(1);
    upper_half = |(pg_all & (mask + ADDR_W'(1)));
    page       = 8'(pg_all & mask);
    word       = page_64k ? 16'(addr[15:2]) : 16'(addr[11:2]);
  end
endmodule // tfd_page_split
`default_nettype wire

//--- design/tfd_frame_decoder.sv
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module tfd_frame_decoder
  import tfd_pkg::*;
#(
  parameter logic       PAGE_SIZE_SEL = PAGE_4K,
  parameter logic [2:0] PAGE_NDX      = 3'd3,
  parameter logic [7:0] CB_COUNT      = 8'd8,
  parameter logic [7:0] S2CB_COUNT    = 8'd4,
  parameter logic       IMPL_EXEMPT   = 1'b1
) (
  input  wire logic                      REF_CLK,
  input  wire logic                      ARST_N,
  input  wire logic [tfd_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [tfd_pkg::DATA_W-1:0] WDATA,
  input  wire logic                      WR,
  input  wire logic                      RD,
  input  wire logic                      SECURE,
  output logic [tfd_pkg::DATA_W-1:0]      RDATA,
  output logic                           SUB_WR,
  output logic                           SUB_RD,
  output var tfd_pkg::tfd_route_s        SUB_ROUTE,
  input  wire logic [tfd_pkg::DATA_W-1:0] SUB_RDATA,
  output logic                           RESTRICT_ON
);

  typedef struct packed {
    logic              global_secure_restrict_enable;
    logic              ns_view;
    logic              rd_q;
    logic              own_q;
    logic [DATA_W-1:0] own_data;
  } tfd_state_s;

  tfd_state_s st, next_st;
  tfd_route_s rt;
  logic       upper_half;
  logic [7:0] page;
  logic [15:0] word;
  logic       blocked;
  logic       own_hit;
  logic [DATA_W-1:0] id1;
  logic [DATA_W-1:0] scr1;

  // Geometry worked out apart from the splitter so the checks stay independent
  localparam int unsigned PG_SHIFT = PAGE_SIZE_SEL ? PAGE_SHIFT_64K : PAGE_SHIFT_4K;
  localparam int unsigned HALF_BIT = PG_SHIFT + 32'(PAGE_NDX) + 32'd1;

  tfd_page_split #(.ADDR_W(ADDR_W)) u_split (
    .addr       (ADDR),
    .page_64k   (PAGE_SIZE_SEL),
    .ndx        ({1'b0, PAGE_NDX}),
    .upper_half (upper_half),
    .page       (page),
    .word       (word)
  );

  always_comb begin
    id1 = '0;
    id1[ID1_CB_LSB +: 8]   = CB_COUNT;
    id1[ID1_S2CB_LSB +: 8] = S2CB_COUNT;
    id1[ID1_NDX_LSB +: 3]  = PAGE_NDX;
    id1[ID1_PGSZ_BIT]      = PAGE_SIZE_SEL;
    scr1 = SCR1_RESET;
    scr1[SCR1_GLOBAL_SECURE_RESTRICT_ENABLE_BIT] = st.global_secure_restrict_enable;
    scr1[SCR1_IMPEX_BIT]  = IMPL_EXEMPT;
  end

  always_comb begin
    rt         = '0;
    rt.page    = page;
    rt.word    = word;
    rt.wdata   = WDATA;
    // Secure side uses the alias to reach the non-secure bank copy
    rt.ns_view = !SECURE || st.ns_view;
    blocked    = 1'b0;
    if (upper_half) begin
      if (page < CB_COUNT) begin
        rt.region = TFD_R_CB;
        // Banks below the stage-2 count are stage-2 format
        if (st.global_secure_restrict_enable && page < S2CB_COUNT && !SECURE) begin
          blocked = 1'b1;
        end
      end else begin
        rt.region = TFD_R_NONE;
      end
    end else if (page == PG_GR0) begin
      rt.region = TFD_R_GR0;
    end else if (page == PG_GR1) begin
      rt.region = TFD_R_GR1;
    end else if (page == PG_IMPL) begin
      rt.region = TFD_R_IMPL;
    end else if (page == PG_PERF) begin
      rt.region = TFD_R_PERF;
    end else if (page == PG_SSD) begin
      rt.region = SECURE ? TFD_R_SSD : TFD_R_NONE;
    end else begin
      rt.region = TFD_R_NONE;
    end
    if (!upper_half && st.global_secure_restrict_enable && !SECURE
        && !(IMPL_EXEMPT && rt.region == TFD_R_IMPL)) begin
      blocked = 1'b1;
    end
    // OR keeps existing secure-only blocking in force
    if (blocked) begin
      rt.region = TFD_R_NONE;
    end
    own_hit = rt.region == TFD_R_GR0
              && (word == 16'(OFF_ID1 >> 2) || word == 16'(OFF_SCR1 >> 2)
                  || word == 16'(OFF_ALIAS >> 2));
    rt.wr = WR && rt.region != TFD_R_NONE && !own_hit;
    rt.rd = RD && rt.region != TFD_R_NONE && !own_hit;
  end

  always_comb begin
    next_st          = st;
    next_st.rd_q     = RD && rt.region != TFD_R_NONE && !own_hit;
    next_st.own_q    = RD && own_hit;
    next_st.own_data = '0;
    if (own_hit && word == 16'(OFF_ID1 >> 2)) begin
      next_st.own_data = id1;
    end else if (own_hit && word == 16'(OFF_SCR1 >> 2)) begin
      next_st.own_data = SECURE ? scr1 : '0;
    end else if (own_hit) begin
      next_st.own_data = SECURE ? DATA_W'(st.ns_view) : '0;
    end
    if (WR && own_hit && SECURE && word == 16'(OFF_SCR1 >> 2)) begin
      next_st.global_secure_restrict_enable = WDATA[SCR1_GLOBAL_SECURE_RESTRICT_ENABLE_BIT];
    end
    if (WR && own_hit && SECURE && word == 16'(OFF_ALIAS >> 2)) begin
      next_st.ns_view = WDATA[0];
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    RDATA = '0;
    if (st.own_q) begin
      RDATA = st.own_data;
    end else if (st.rd_q) begin
      RDATA = SUB_RDATA;
    end
  end

  assign SUB_ROUTE   = rt;
  assign SUB_WR      = rt.wr;
  assign SUB_RD      = rt.rd;
  assign RESTRICT_ON = st.global_secure_restrict_enable;

  a_ssd_ns_block: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (!upper_half && page == PG_SSD && !SECURE) |-> !SUB_WR && !SUB_RD)
    else $error("non-secure access reached determination page");
  a_reserved_pages: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (!upper_half && page > PG_SSD) |-> SUB_ROUTE.region == TFD_R_NONE)
    else $error("reserved global page routed");
  a_top_raz: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (RD && upper_half && page >= CB_COUNT) |=> RDATA == '0)
    else $error("unimplemented bank read nonzero");
  a_restrict_gr: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (RESTRICT_ON && !SECURE && !upper_half && page != PG_IMPL) |-> !SUB_WR && !SUB_RD)
    else $error("restricted global access passed");
  a_restrict_cb: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (RESTRICT_ON && !SECURE && upper_half && page < S2CB_COUNT) |-> !SUB_WR && !SUB_RD)
    else $error("restricted stage-2 bank access passed");
  a_bank_route: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (WR && upper_half && page < CB_COUNT && (SECURE || !RESTRICT_ON))
    |-> SUB_WR && SUB_ROUTE.region == TFD_R_CB && SUB_ROUTE.page == page)
    else $error("bank write misrouted");
  a_restrict_set: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (WR && !SECURE && own_hit && word == 16'(OFF_SCR1 >> 2))
    |=> $stable(RESTRICT_ON))
    else $error("non-secure write changed restrict bit");
  a_id_read: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (RD && own_hit && word == 16'(OFF_ID1 >> 2)) |=> RDATA[7:0] == CB_COUNT)
    else $error("bank count not reported");
  a_bank_view: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !SECURE |-> SUB_ROUTE.ns_view)
    else $error("non-secure access saw secure copy");

  // Routing, refusal and read-back checks
  a_half_bit: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    upper_half == 1'(ADDR >> HALF_BIT))
    else $error("frame half decoded from wrong address bit");

  a_word_route: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    SUB_ROUTE.word == 16'(ADDR[PG_SHIFT-1:2]))
    else $error("word index inside page wrong");

  a_wr_source: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    SUB_WR |-> WR)
    else $error("forwarded write without a write strobe");

  a_rd_source: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    SUB_RD |-> RD)
    else $error("forwarded read without a read strobe");

  a_wdata_pass: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    SUB_WR |-> SUB_ROUTE.wdata == WDATA)
    else $error("forwarded write data differs");

  a_own_local: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    own_hit |-> !SUB_WR && !SUB_RD)
    else $error("decoder register access leaked to region");

  a_gr0_route: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (WR && !upper_half && page == PG_GR0 && !own_hit && (SECURE || !RESTRICT_ON))
    |-> SUB_WR && SUB_ROUTE.region == TFD_R_GR0)
    else $error("global space zero write misrouted");

  a_gr1_route: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (WR && !upper_half && page == PG_GR1 && (SECURE || !RESTRICT_ON))
    |-> SUB_WR && SUB_ROUTE.region == TFD_R_GR1)
    else $error("global space one write misrouted");

  a_perf_route: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (WR && !upper_half && page == PG_PERF && (SECURE || !RESTRICT_ON))
    |-> SUB_WR && SUB_ROUTE.region == TFD_R_PERF)
    else $error("performance page write misrouted");

  a_impl_exempt: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (IMPL_EXEMPT && WR && !upper_half && page == PG_IMPL)
    |-> SUB_WR && SUB_ROUTE.region == TFD_R_IMPL)
    else $error("exempt page write was blocked");

  a_ssd_secure: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (RD && SECURE && !upper_half && page == PG_SSD)
    |-> SUB_RD && SUB_ROUTE.region == TFD_R_SSD)
    else $error("secure determination read blocked");

  a_cb_open: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (WR && upper_half && page >= S2CB_COUNT && page < CB_COUNT)
    |-> SUB_WR && SUB_ROUTE.region == TFD_R_CB)
    else $error("full-format bank write blocked");

  a_bank_read: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (RD && upper_half && page < CB_COUNT && (SECURE || !RESTRICT_ON))
    |-> SUB_RD && SUB_ROUTE.page == page)
    else $error("bank read misrouted");

  a_top_wi: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (upper_half && page >= CB_COUNT) |-> !SUB_WR && !SUB_RD)
    else $error("unimplemented bank access forwarded");

  a_sub_pass: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    SUB_RD |=> RDATA == SUB_RDATA)
    else $error("region read data not returned");

  a_rdata_idle: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !RD |=> RDATA == '0)
    else $error("read data nonzero without a read");

  a_scr1_ns_raz: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (RD && !SECURE && !upper_half && page == PG_GR0 && word == 16'(OFF_SCR1 >> 2))
    |=> RDATA == '0)
    else $error("non-secure read saw secure configuration");

  a_restrict_hold: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !(WR && SECURE && own_hit && word == 16'(OFF_SCR1 >> 2))
    |=> $stable(RESTRICT_ON))
    else $error("restrict bit changed without secure write");

  a_alias_ns_keep: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (WR && !SECURE && own_hit && word == 16'(OFF_ALIAS >> 2))
    |=> $stable(st.ns_view))
    else $error("non-secure write changed alias view");

  a_alias_read: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (RD && SECURE && own_hit && word == 16'(OFF_ALIAS >> 2))
    |=> RDATA == DATA_W'($past(st.ns_view)))
    else $error("alias view read back wrong");

  a_id_fields: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (RD && own_hit && word == 16'(OFF_ID1 >> 2))
    |=> RDATA[ID1_S2CB_LSB +: 8] == S2CB_COUNT && RDATA[ID1_NDX_LSB +: 3] == PAGE_NDX
        && RDATA[ID1_PGSZ_BIT] == PAGE_SIZE_SEL)
    else $error("identification fields wrong");

endmodule // tfd_frame_decoder
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tfd_pkg::*;
  localparam logic [DATA_W-1:0] ID_WORD = 32'h3004_0008;
  logic              REF_CLK   = 1'b0;
  logic              ARST_N    = 1'b0;
  logic [ADDR_W-1:0] ADDR      = '0;
  logic [DATA_W-1:0] WDATA     = '0;
  logic              WR        = 1'b0;
  logic              RD        = 1'b0;
  logic              SECURE    = 1'b0;
  logic [DATA_W-1:0] SUB_RDATA = '0;
  logic [DATA_W-1:0] RDATA;
  logic              SUB_WR;
  logic              SUB_RD;
  logic              RESTRICT_ON;
  tfd_route_s        SUB_ROUTE;
  int                num_errors  = 0;
  int                comparisons = 0;
  int                cycles      = 0;
  int                seed        = 69386;
  int                m_restrict  = 0;
  int                m_alias     = 0;
  int                rd_kind     = 0;
  logic [DATA_W-1:0] rd_exp      = '0;

  tfd_frame_decoder #(.PAGE_SIZE_SEL(PAGE_4K), .PAGE_NDX(3'd3), .CB_COUNT(8'd8),
    .S2CB_COUNT(8'd4), .IMPL_EXEMPT(1'b1)) u_dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .SECURE(SECURE), .RDATA(RDATA),
    .SUB_WR(SUB_WR), .SUB_RD(SUB_RD), .SUB_ROUTE(SUB_ROUTE), .SUB_RDATA(SUB_RDATA),
    .RESTRICT_ON(RESTRICT_ON));

  initial begin
    forever #20 REF_CLK = ~REF_CLK;
  end

  task automatic close_out();
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, well above the fewer than a thousand cycles the run needs
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One bus cycle; also checks the answer to the previous cycle's read
  task automatic access(input logic w, input logic r, input logic s,
                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int   pg;
    logic up;
    logic blk;
    logic own;
    @(posedge REF_CLK);
    WR        <= w;
    RD        <= r;
    SECURE    <= s;
    ADDR      <= a;
    WDATA     <= d;
    SUB_RDATA <= $random(seed);
    @(negedge REF_CLK);
    if (rd_kind == 1) chk_data(RDATA, SUB_RDATA);
    else chk_data(RDATA, rd_exp);
    chk_flag(RESTRICT_ON, m_restrict[0]);
    up  = a[16];
    pg  = a[15:12];
    own = !up && pg == 0 && ({a[11:2], 2'b00} inside {OFF_ID1, OFF_SCR1, OFF_ALIAS});
    blk = up ? (pg >= 8 || (m_restrict != 0 && !s && pg < 4))
             : (pg >= 5 || (pg == 4 && !s) || (m_restrict != 0 && !s && pg != 2));
    rd_kind = 0;
    rd_exp  = '0;
    if (!own) begin
      chk_flag(SUB_WR, w && !blk);
      chk_flag(SUB_RD, r && !blk);
      if (!blk && (w || r)) begin
        chk_data(32'(SUB_ROUTE.region), up ? 32'd6 : 32'(pg + 1));
        chk_data(32'(SUB_ROUTE.page), 32'(pg));
        chk_flag(SUB_ROUTE.ns_view, !s || m_alias != 0);
        chk_data(32'(SUB_ROUTE.word), 32'(a[11:2]));
        chk_data(SUB_ROUTE.wdata, d);
      end
      if (r && !blk) rd_kind = 1;
    end else if ({a[11:2], 2'b00} == OFF_ID1) begin
      rd_exp = (r && !blk) ? ID_WORD : '0;
    end else if ({a[11:2], 2'b00} == OFF_SCR1) begin
      rd_exp = (r && s) ? ((32'(m_restrict) << 28) | 32'h0800_0000) : '0;
      if (w && s) m_restrict = d[28];
    end else begin
      rd_exp = (r && s) ? 32'(m_alias) : '0;
      if (w && s) m_alias = d[0];
    end
    if (own) chk_flag(SUB_WR | SUB_RD, 1'b0);
  endtask

  task automatic random_run(input int n);
    logic [ADDR_W-1:0] a;
    int                k;
    for (int i = 0; i < n; i++) begin
      // Base at zero meets the double-half alignment
      a = {7'h00, 17'($random(seed))};
      if (a[16:12] == 5'h00) a[8] = 1'b1;
      k = {$random(seed)} % 3;
      access(k == 1, k == 2, 1'($random(seed)), a, $random(seed));
    end
  endtask

  initial begin
    repeat (8) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk_data(RDATA, '0);
    chk_flag(RESTRICT_ON, 1'b0);
    @(posedge REF_CLK);
    ARST_N <= 1'b1;
    access(0, 1, 1, 24'(OFF_ID1), '0);
    access(0, 1, 0, 24'(OFF_ID1), '0);
    access(0, 1, 1, 24'(OFF_SCR1), '0);
    access(1, 0, 0, 24'(OFF_SCR1), 32'h1000_0000);
    access(0, 1, 0, 24'(OFF_SCR1), '0);
    for (int m = 0; m < 2; m++) begin
      access(1, 0, 1, 24'(OFF_SCR1), 32'(m) << 28);
      access(0, 1, 0, 24'(OFF_ID1), '0);
      for (int p = 0; p < 64; p++) begin
        access(1, 0, p[5], 24'(p[4:0]) << 12 | 24'h000040, $random(seed));
        access(0, 1, p[5], 24'(p[4:0]) << 12 | 24'h000ffc, '0);
      end
      random_run(150);
    end
    access(1, 0, 1, 24'(OFF_SCR1), '0);
    access(1, 0, 0, 24'(OFF_ALIAS), 32'h0000_0001);
    access(0, 1, 1, 24'(OFF_ALIAS), '0);
    access(1, 0, 1, 24'(OFF_ALIAS), 32'h0000_0001);
    random_run(150);
    access(0, 1, 1, 24'(OFF_ALIAS), '0);
    access(1, 0, 1, 24'(OFF_SCR1), 32'h1000_0000);
    access(0, 0, 0, '0, '0);
    // Reset in mid-run must drop the restriction and the alias view
    @(posedge REF_CLK);
    ARST_N <= 1'b0;
    m_restrict = 0;
    m_alias    = 0;
    rd_kind    = 0;
    rd_exp     = '0;
    repeat (2) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    random_run(40);
    access(0, 1, 1, 24'(OFF_ALIAS), '0);
    access(0, 0, 0, '0, '0);
    close_out();
  end
endmodule // tb
`default_nettype wire
